/* File: rtl/ldc_pkg.sv */
/*
  Package for the loop DAC configuration register bank: register
  offsets, field positions, reset values, commands and carrier types.
  Assumes a single 25 MHz clock and an Avalon-MM slave with waitrequest.
*/
// Notes on behaviour
// R1: Key 0x95 unlocks; other values lock.
// R2: Output code frozen while unlocked; code still takes the fault level code whenever error is set.
// R3: Force field 01 sets, 10 clears error.
// R4: Error asserted after power-on.
// R5: Valid frame clears error.
// R6: Force command bits self clear.
// R7: Soft reset bit restores defaults, self clears.
// R8: Host writes zero to reserved bits.
// R9: Acknowledge per valid frame when enabled.
// R10: Framing errors reported only when enabled.
// R11: Parity errors reported only when enabled.
// R12: Idle channel reported only when enabled.
// R13: Loop faults reported only when enabled.
// R14: Threshold is stored run value plus one; the code uses only the low four bits of the run register.
// R15: Error entered after threshold consecutive errors.
// R16: Low level: low register upper byte, zero lower.
// R17: Low register defaults to 0x24.
// R18: High level: high register, default 0xE8.
// R19: Valid frame zeroes consecutive error counter.
// R20: Locked registers ignore writes except key.
package ldc_pkg;
  localparam logic [2:0] ADDR_KEY   = 3'h0;
  localparam logic [2:0] ADDR_CTRL  = 3'h1;
  localparam logic [2:0] ADDR_REPEN = 3'h2;
  localparam logic [2:0] ADDR_RUN   = 3'h3;
  localparam logic [2:0] ADDR_LOW   = 3'h4;
  localparam logic [2:0] ADDR_HIGH  = 3'h5;
  localparam logic [2:0] ADDR_STAT  = 3'h6;

  localparam logic [7:0] KEY_UNLOCK  = 8'h95;
  localparam logic [7:0] RST_KEY     = 8'h00;
  localparam logic [7:0] RST_CTRL    = 8'h08;
  localparam logic [7:0] RST_REPEN   = 8'h1f;
  localparam logic [7:0] RST_RUN     = 8'h08;
  localparam logic [7:0] RST_LOW     = 8'h24;
  localparam logic [7:0] RST_HIGH    = 8'he8;
  localparam logic [7:0] CODE_LOW_BYTE = 8'h00;

  localparam int CTRL_SRST   = 0;
  localparam int CTRL_FORCE_LO = 3;
  localparam int CTRL_FORCE_HI = 4;
  localparam int EN_LOOP    = 0;
  localparam int EN_CHANNEL = 1;
  localparam int EN_PARITY  = 2;
  localparam int EN_FRAME   = 3;
  localparam int EN_ACK     = 4;

  localparam logic [1:0] FORCE_SET   = 2'b01;
  localparam logic [1:0] FORCE_CLEAR = 2'b10;

  typedef enum logic [1:0] {
    LDC_IDLE = 2'b00,
    LDC_WAIT = 2'b01,
    LDC_DONE = 2'b11
  } ldc_bus_state_type;

  typedef struct packed {
    logic valid_frame;
    logic frame_error;
    logic parity_error;
    logic channel_idle;
    logic loop_fault;
  } ldc_link_event_type;

  typedef struct packed {
    logic frame;
    logic parity;
    logic channel;
    logic loop;
  } ldc_report_type;
endpackage

/* File: rtl/ldc_run_counter.sv */
/*
  Consecutive framing/parity error counter with programmable threshold.
  Assumes events are one-cycle pulses synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ldc_run_counter
#(
  parameter int WIDTH = 4
)
(
  input  wire logic             mclk_i,
  input  wire logic             clear_i,
  input  wire logic             error_i,
  input  wire logic             good_i,
  input  wire logic [WIDTH-1:0] limit_i,
  output logic                  hit_o
);
  logic [WIDTH:0] count_reg;
  logic [WIDTH:0] count_next;
  logic           hit_next;
  logic           hit_reg;

  always_comb
  begin
    count_next = count_reg;
    hit_next   = 1'b0;
    // R19: frame resets count
    if (clear_i || good_i)
    begin
      count_next = '0;
    end
    else if (error_i)
    begin
      // R14: threshold is limit plus one
      if (count_reg + (WIDTH+1)'(1) >= {1'b0, limit_i} + (WIDTH+1)'(1))
      begin
        // R15: run reached threshold
        hit_next   = 1'b1;
        count_next = '0;
      end
      else
      begin
        count_next = count_reg + (WIDTH+1)'(1);
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    count_reg <= count_next;
    hit_reg   <= hit_next;
  end

  assign hit_o = hit_reg;
endmodule // ldc_run_counter
`default_nettype wire

/* File: rtl/ldc_config_regs.sv */
/*
  Configuration register bank of a single-wire loop DAC: write key,
  commands, report enables, error run limit, fault levels and the
  resulting output code. Assumes link events arrive as decoded pulses
  and that the host reaches the registers over Avalon-MM.
*/
`timescale 1ns/1ps
`default_nettype none
module ldc_config_regs
(
  input  wire logic                        mclk_i,
  input  wire logic                        rst_i,
  input  wire logic [2:0]                  avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [31:0]                 avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic [31:0]                      avs_readdata_o,
  output logic                             avs_waitrequest_o,
  input  wire ldc_pkg::ldc_link_event_type link_event_i,
  input  wire logic [15:0]                 frame_code_i,
  input  wire logic                        fault_level_select_i,
  output logic [15:0]                      output_code_o,
  output logic                             error_state_o,
  output logic                             ack_pulse_o,
  output ldc_pkg::ldc_report_type          report_o
);
  ldc_pkg::ldc_bus_state_type state_reg;
  ldc_pkg::ldc_bus_state_type state_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0]  write_key_reg;
  logic [7:0]  write_key_next;
  logic [7:0]  control_cmd_reg;
  logic [7:0]  control_cmd_next;
  logic [7:0]  report_enable_reg;
  logic [7:0]  report_enable_next;
  logic [7:0]  error_run_reg;
  logic [7:0]  error_run_next;
  logic [7:0]  low_fault_reg;
  logic [7:0]  low_fault_next;
  logic [7:0]  high_fault_reg;
  logic [7:0]  high_fault_next;
  logic        error_reg;
  logic        error_next;
  logic [15:0] dac_code_reg;
  logic [15:0] dac_code_next;
  logic [15:0] code_reg;
  logic [15:0] code_next;
  logic        ack_reg;
  logic        ack_next;
  ldc_pkg::ldc_report_type report_reg;
  ldc_pkg::ldc_report_type report_next;
  logic        soft_rst;
  logic        any_rst;
  logic        unlocked;
  logic        wr_take;
  logic        run_hit;
  logic [1:0]  force_cmd;

  assign soft_rst = control_cmd_reg[ldc_pkg::CTRL_SRST];
  assign any_rst  = rst_i || soft_rst;
  assign unlocked = (write_key_reg == ldc_pkg::KEY_UNLOCK);
  // A write lands at the edge where the master sees waitrequest low.
  assign wr_take  = avs_write_i && (state_reg == ldc_pkg::LDC_DONE)
                    && avs_byteenable_i[0];
  assign force_cmd = control_cmd_reg[ldc_pkg::CTRL_FORCE_HI:
                                     ldc_pkg::CTRL_FORCE_LO];

  ldc_run_counter #(
    .WIDTH (4)
  ) u_run (
    .mclk_i  (mclk_i),
    .clear_i (any_rst),
    .error_i (link_event_i.frame_error || link_event_i.parity_error),
    .good_i  (link_event_i.valid_frame),
    .limit_i (error_run_reg[3:0]),
    .hit_o   (run_hit)
  );

  // Two wait states: request seen in IDLE, then answered in DONE two cycles later.
  always_comb
  begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    case (state_reg)
      ldc_pkg::LDC_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          state_next = ldc_pkg::LDC_WAIT;
        end
      end
      ldc_pkg::LDC_WAIT:
      begin
        state_next = ldc_pkg::LDC_DONE;
        rdata_next = '0;
        case (avs_address_i)
          ldc_pkg::ADDR_KEY:   rdata_next[7:0] = write_key_reg;
          ldc_pkg::ADDR_CTRL:  rdata_next[7:0] = control_cmd_reg;
          ldc_pkg::ADDR_REPEN: rdata_next[7:0] = report_enable_reg;
          ldc_pkg::ADDR_RUN:   rdata_next[7:0] = error_run_reg;
          ldc_pkg::ADDR_LOW:   rdata_next[7:0] = low_fault_reg;
          ldc_pkg::ADDR_HIGH:  rdata_next[7:0] = high_fault_reg;
          ldc_pkg::ADDR_STAT:  rdata_next[1:0] = {unlocked, error_reg};
          default:             rdata_next = '0;
        endcase
      end
      ldc_pkg::LDC_DONE:
      begin
        state_next = ldc_pkg::LDC_IDLE;
      end
      default:
      begin
        state_next = ldc_pkg::LDC_IDLE;
      end
    endcase
  end

  always_comb
  begin
    write_key_next     = write_key_reg;
    control_cmd_next   = control_cmd_reg;
    report_enable_next = report_enable_reg;
    error_run_next     = error_run_reg;
    low_fault_next     = low_fault_reg;
    high_fault_next    = high_fault_reg;
    error_next         = error_reg;
    // R6: force bits self clear
    control_cmd_next[ldc_pkg::CTRL_FORCE_HI:ldc_pkg::CTRL_FORCE_LO] = 2'b00;
    // R3: force clear command
    if (force_cmd == ldc_pkg::FORCE_CLEAR)
    begin
      error_next = 1'b0;
    end
    // R5: valid frame clears error
    if (link_event_i.valid_frame)
    begin
      error_next = 1'b0;
    end
    // R3: force set wins last
    if (force_cmd == ldc_pkg::FORCE_SET)
    begin
      error_next = 1'b1;
    end
    // R15: threshold run enters error
    if (run_hit)
    begin
      error_next = 1'b1;
    end
    if (wr_take)
    begin
      // R1: any key write other than 0x95 relocks
      if (avs_address_i == ldc_pkg::ADDR_KEY)
      begin
        write_key_next = avs_writedata_i[7:0];
      end
      // R20: locked writes ignored
      else if (unlocked)
      begin
        case (avs_address_i)
          ldc_pkg::ADDR_CTRL:  control_cmd_next   = avs_writedata_i[7:0];
          ldc_pkg::ADDR_REPEN: report_enable_next = avs_writedata_i[7:0];
          ldc_pkg::ADDR_RUN:   error_run_next     = avs_writedata_i[7:0];
          ldc_pkg::ADDR_LOW:   low_fault_next     = avs_writedata_i[7:0];
          ldc_pkg::ADDR_HIGH:  high_fault_next    = avs_writedata_i[7:0];
          default:             control_cmd_next   = control_cmd_next;
        endcase
      end
    end
  end

  always_comb
  begin
    dac_code_next = dac_code_reg;
    code_next     = code_reg;
    ack_next      = 1'b0;
    report_next   = '0;
    // R2: code frozen while unlocked
    if (link_event_i.valid_frame && !unlocked)
    begin
      dac_code_next = frame_code_i;
    end
    if (error_reg)
    begin
      // R16: low level code
      // R18: high level code
      code_next = fault_level_select_i
                  ? {high_fault_reg, ldc_pkg::CODE_LOW_BYTE}
                  : {low_fault_reg, ldc_pkg::CODE_LOW_BYTE};
    end
    else if (!unlocked)
    begin
      code_next = dac_code_reg;
    end
    // R9: acknowledge gated by enable
    ack_next = link_event_i.valid_frame
               && report_enable_reg[ldc_pkg::EN_ACK];
    // R10: framing report gate
    report_next.frame   = link_event_i.frame_error
                          && report_enable_reg[ldc_pkg::EN_FRAME];
    // R11: parity report gate
    report_next.parity  = link_event_i.parity_error
                          && report_enable_reg[ldc_pkg::EN_PARITY];
    // R12: idle channel gate
    report_next.channel = link_event_i.channel_idle
                          && report_enable_reg[ldc_pkg::EN_CHANNEL];
    // R13: loop fault gate
    report_next.loop    = link_event_i.loop_fault
                          && report_enable_reg[ldc_pkg::EN_LOOP];
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ldc_pkg::LDC_IDLE;
      rdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
    end
  end

  // R7: soft reset restores defaults
  always_ff @(posedge mclk_i)
  begin
    if (any_rst)
    begin
      write_key_reg     <= ldc_pkg::RST_KEY;
      // Reset value keeps bit 0 clear, so the soft reset ends itself.
      control_cmd_reg   <= ldc_pkg::RST_CTRL;
      report_enable_reg <= ldc_pkg::RST_REPEN;
      error_run_reg     <= ldc_pkg::RST_RUN;
      // R17: low level default
      low_fault_reg     <= ldc_pkg::RST_LOW;
      high_fault_reg    <= ldc_pkg::RST_HIGH;
      // R4: error set at power-on
      error_reg         <= 1'b1;
      dac_code_reg      <= '0;
      code_reg          <= '0;
      ack_reg           <= 1'b0;
      report_reg        <= '0;
    end
    else
    begin
      write_key_reg     <= write_key_next;
      control_cmd_reg   <= control_cmd_next;
      report_enable_reg <= report_enable_next;
      error_run_reg     <= error_run_next;
      low_fault_reg     <= low_fault_next;
      high_fault_reg    <= high_fault_next;
      error_reg         <= error_next;
      dac_code_reg      <= dac_code_next;
      code_reg          <= code_next;
      ack_reg           <= ack_next;
      report_reg        <= report_next;
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = !(state_reg == ldc_pkg::LDC_DONE);
  assign output_code_o     = code_reg;
  assign error_state_o     = error_reg;
  assign ack_pulse_o       = ack_reg;
  assign report_o          = report_reg;
endmodule // ldc_config_regs
`default_nettype wire

/* File: verif/ldc_config_regs_checker.sv */
/*
  Port assertions for the loop DAC configuration register bank.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ldc_config_regs_checker
(
  input wire logic                        mclk_i,
  input wire logic                        rst_i,
  input wire logic                        avs_write_i,
  input wire ldc_pkg::ldc_link_event_type link_event_i,
  input wire logic [15:0]                 output_code_o,
  input wire logic                        error_state_o,
  input wire logic                        ack_pulse_o,
  input wire ldc_pkg::ldc_report_type     report_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  AST_RESET_ERROR:
    assert property (disable iff (1'b0) $fell(rst_i) |-> error_state_o)
    else $error("error state not set after reset");
  AST_FRAME_CLEARS:
    assert property (link_event_i.valid_frame && !avs_write_i
      && !$past(avs_write_i) && !$past(link_event_i.frame_error)
      && !$past(link_event_i.parity_error) |=> !error_state_o)
    else $error("valid frame did not clear error");
  AST_ACK_CAUSE:
    assert property (ack_pulse_o |-> $past(link_event_i.valid_frame))
    else $error("ack without valid frame");
  AST_FRAME_REPORT:
    assert property (report_o.frame |-> $past(link_event_i.frame_error))
    else $error("frame report without cause");
  AST_PARITY_REPORT:
    assert property (report_o.parity |-> $past(link_event_i.parity_error))
    else $error("parity report without cause");
  AST_CHANNEL_REPORT:
    assert property (report_o.channel |-> $past(link_event_i.channel_idle))
    else $error("channel report without cause");
  AST_LOOP_REPORT:
    assert property (report_o.loop |-> $past(link_event_i.loop_fault))
    else $error("loop report without cause");
  AST_ERROR_LOW_BYTE:
    assert property (error_state_o && $past(error_state_o)
      |-> output_code_o[7:0] == 8'h00)
    else $error("error code low byte not zero");
endmodule // ldc_config_regs_checker
bind ldc_config_regs ldc_config_regs_checker ldc_config_regs_checker_i
  (.mclk_i, .rst_i, .avs_write_i, .link_event_i, .output_code_o,
   .error_state_o, .ack_pulse_o, .report_o);
`default_nettype wire

/* File: verif/ldc_link_host_model.sv */
/*
  Far side of the link: issues decoded link events one cycle long.
  Assumes the bench calls send from its main sequence.
*/
`timescale 1ns/1ps
`default_nettype none
module ldc_link_host_model
(
  input  wire logic                   mclk_i,
  output ldc_pkg::ldc_link_event_type link_event_o,
  output logic [15:0]                 frame_code_o
);
  initial
  begin
    link_event_o = '0;
    frame_code_o = 16'h0000;
  end
  task automatic send(input logic [4:0] ev, input logic [15:0] code);
    @(posedge mclk_i);
    link_event_o <= ev;
    frame_code_o <= code;
    @(posedge mclk_i);
    link_event_o <= '0;
    // The code means nothing outside a frame, so it is scrambled here.
    frame_code_o <= ~code;
  endtask
endmodule // ldc_link_host_model
`default_nettype wire

/* File: verif/ldc_config_regs_test.sv */
/*
  Self-checking bench for the configuration register bank.
  Assumes the checker is bound and the link model drives events.
*/
`timescale 1ns/1ps
`default_nettype none
module ldc_config_regs_test;
  logic                       mclk_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic [2:0]                 avs_address_i = 3'h0;
  logic                       avs_read_i = 1'b0;
  logic                       avs_write_i = 1'b0;
  logic [31:0]                avs_writedata_i = 32'h0000_0000;
  logic [3:0]                 avs_byteenable_i = 4'h0;
  logic                       fault_level_select_i = 1'b0;
  logic [31:0]                avs_readdata_o;
  logic                       avs_waitrequest_o;
  logic [15:0]                output_code_o;
  logic                       error_state_o;
  logic                       ack_pulse_o;
  ldc_pkg::ldc_report_type    report_o;
  ldc_pkg::ldc_link_event_type link_event;
  logic [15:0]                frame_code;
  int                         n_errors = 0;
  int                         tests_run = 0;
  int                         n_ack = 0;
  int                         n_rep [4] = '{0, 0, 0, 0};
  // Force field resets to the set pattern and clears itself at once.
  logic [7:0] dflt [5] = '{8'h00, 8'h00, 8'h1f, 8'h08, 8'h24};
  logic [1:0] pat [5] = '{2'b10, 2'b00, 2'b01, 2'b11, 2'b10};
  logic       perr [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  always #20 mclk_i = ~mclk_i;

  ldc_config_regs ldc_config_regs_i (.mclk_i, .rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .link_event_i(link_event),
    .frame_code_i(frame_code), .fault_level_select_i, .output_code_o,
    .error_state_o, .ack_pulse_o, .report_o);
  ldc_link_host_model ldc_link_host_model_i (.mclk_i,
    .link_event_o(link_event), .frame_code_o(frame_code));

  always @(negedge mclk_i)
  begin
    n_ack += int'(ack_pulse_o === 1'b1);
    for (int k = 0; k < 4; k++)
      n_rep[k] += int'(report_o[k] === 1'b1);
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string s, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int i;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h00_0000, d};
    avs_byteenable_i <= 4'h1;
    for (i = 0; i < 20; i++)
    begin
      @(negedge mclk_i);
      if (avs_waitrequest_o === 1'b0)
        break;
    end
    q = avs_readdata_o[7:0];
    @(posedge mclk_i);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (i == 20)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e, string s);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(s, {8'h00, e}, {8'h00, q});
  endtask

  task automatic ev(input logic [4:0] e, input logic [15:0] c);
    ldc_link_host_model_i.send(e, c);
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task automatic errchk(input logic e);
    chk("error", {15'h0000, e}, {15'h0000, error_state_o});
  endtask

  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    errchk(1'b1);
    for (int k = 0; k < 5; k++)
      rd(3'(k), dflt[k], "default");
    rd(3'h7, 8'h00, "unmapped");
    ev(5'h10, 16'h1234);
    errchk(1'b0);
    chk("code", 16'h1234, output_code_o);
    chk("acks", 16'h0001, 16'(n_ack));
    ev(5'h02, 16'h0000);
    ev(5'h01, 16'h0000);
    chk("channel", 16'h0001, 16'(n_rep[1]));
    chk("loop", 16'h0001, 16'(n_rep[0]));
    wr(3'h3, 8'h01);
    rd(3'h3, 8'h08, "locked");
    wr(3'h0, 8'h95);
    wr(3'h3, 8'h01);
    rd(3'h3, 8'h01, "run");
    wr(3'h2, 8'h08);
    ev(5'h10, 16'h5678);
    chk("held", 16'h1234, output_code_o);
    wr(3'h0, 8'h3c);
    wr(3'h3, 8'h05);
    rd(3'h3, 8'h01, "relocked");
    ev(5'h10, 16'h5678);
    chk("code", 16'h5678, output_code_o);
    chk("acks", 16'h0001, 16'(n_ack));
    ev(5'h08, 16'h0000);
    ev(5'h10, 16'h5678);
    ev(5'h08, 16'h0000);
    errchk(1'b0);
    ev(5'h04, 16'h0000);
    @(negedge mclk_i);
    errchk(1'b1);
    chk("errcode", 16'h2400, output_code_o);
    chk("frame", 16'h0002, 16'(n_rep[3]));
    chk("parity", 16'h0000, 16'(n_rep[2]));
    @(posedge mclk_i);
    fault_level_select_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk("hicode", 16'he800, output_code_o);
    wr(3'h0, 8'h95);
    for (int k = 0; k < 5; k++)
    begin
      wr(3'h1, {3'h0, pat[k], 3'h0});
      rd(3'h1, 8'h00, "ctrl");
      errchk(perr[k]);
    end
    wr(3'h3, 8'h05);
    wr(3'h1, 8'h01);
    rd(3'h1, 8'h00, "ctrl");
    rd(3'h3, 8'h08, "run");
    rd(3'h0, 8'h00, "key");
    errchk(1'b1);
    end_of_test();
  end
endmodule // ldc_config_regs_test
`default_nettype wire
